// ### wgst_pkg.sv
// Package: constants, field layout and types of the waveform gate select timer
package wgst_pkg;

  // ****************************************************************
  // Register map (byte offsets)
  // ****************************************************************
  localparam logic [7:0] WGST_OFS_SETUP0 = 8'h00;
  localparam logic [7:0] WGST_OFS_SETUP1 = 8'h04;
  localparam logic [7:0] WGST_OFS_SETUP2 = 8'h08;
  localparam logic [7:0] WGST_OFS_TCNT0 = 8'h0C;
  localparam logic [7:0] WGST_OFS_TCNT1 = 8'h10;
  localparam logic [7:0] WGST_OFS_TCNT2 = 8'h14;
  localparam logic [7:0] WGST_OFS_SHUTDOWN = 8'h18;
  localparam logic [7:0] WGST_OFS_RUNCTRL = 8'h1C;
  localparam logic [7:0] WGST_OFS_STATUS = 8'h20;

  // ****************************************************************
  // Setup register fields
  // ****************************************************************
  localparam int WGST_DIV_LSB = 0;
  localparam int WGST_MODE_LSB = 3;
  localparam int WGST_GATE_LSB = 6;
  localparam int WGST_PSEL_LSB = 8;
  localparam int WGST_REFL_LSB = 10;
  localparam int WGST_POL_LSB = 12;
  localparam logic [15:0] WGST_SETUP_MASK = 16'h3FFF;
  localparam logic [15:0] WGST_SETUP_RST = 16'h0000;
  localparam logic [15:0] WGST_TCNT_RST = 16'h0000;

  localparam logic [2:0] WGST_MODE_THRU = 3'h0;
  localparam logic [2:0] WGST_MODE_RTPULSE = 3'h1;
  localparam logic [2:0] WGST_MODE_TPULSE = 3'h2;
  localparam logic [2:0] WGST_MODE_RTDEAD = 3'h4;
  localparam logic [2:0] WGST_MODE_PDEAD = 3'h7;

  localparam logic [1:0] WGST_PSEL_U0 = 2'h0;
  localparam logic [1:0] WGST_PSEL_U2 = 2'h1;
  localparam logic [1:0] WGST_PSEL_U4 = 2'h2;

  localparam logic [1:0] WGST_POL_NONE = 2'h0;
  localparam logic [1:0] WGST_POL_BOTH = 2'h1;
  localparam logic [1:0] WGST_POL_OUT0 = 2'h2;
  localparam logic [1:0] WGST_POL_OUT1 = 2'h3;

  // ****************************************************************
  // Shutdown control and status fields
  // ****************************************************************
  localparam int WGST_SD_EN_BIT = 0;
  localparam int WGST_SD_NW_LSB = 1;
  localparam int WGST_SD_FORCE_BIT = 4;
  localparam logic [3:0] WGST_SD_RST = 4'h0;
  localparam int WGST_STAT_FLAG_BIT = 8;
  localparam logic [16:0] WGST_TCNT_FULL = 17'h10000;

  // ****************************************************************
  // Bus and types
  // ****************************************************************
  localparam logic [1:0] WGST_HRESP_OKAY = 2'h0;

  typedef enum logic [1:0] {
    WGST_T_IDLE = 2'b01,
    WGST_T_RUN = 2'b10
  } wgst_tstate_t;

  // Prescaler mask: divide by 2**code, codes above 6 act as 6
  function automatic logic [5:0] wgst_div_mask(input logic [2:0] code);
    logic [2:0] c;
    c = (code == 3'h7) ? 3'h6 : code;
    return 6'((7'h01 << c) - 7'h01);
  endfunction : wgst_div_mask

  // Noise filter width in cycles
  function automatic logic [5:0] wgst_nz_width(input logic [2:0] code);
    case (code)
      3'h0: return 6'h00;
      3'h1: return 6'h04;
      3'h2: return 6'h08;
      3'h3: return 6'h10;
      default: return 6'h20;
    endcase
  endfunction : wgst_nz_width

endpackage : wgst_pkg

// ### wgst_wave_timer.sv
// Module: 16-bit down-counting waveform timer with prescaler and reload
`timescale 1ns/100ps
module wgst_wave_timer
  import wgst_pkg::*;
(
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic [2:0] div_code,
  input wire logic [15:0] init_count,
  input wire logic start,
  input wire logic clear,
  input wire logic reload_en,
  output logic running,
  output logic expire
);

  wgst_tstate_t state_r, state_nxt;
  logic [16:0] cnt_r, cnt_nxt;
  logic [5:0] pre_r, pre_nxt;
  logic expire_r, expire_nxt;
  logic [16:0] load_val;
  logic tick;

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    load_val = (init_count == 16'h0000) ? WGST_TCNT_FULL : {1'b0, init_count};
    tick = (pre_r & wgst_div_mask(div_code)) == wgst_div_mask(div_code);
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    pre_nxt = pre_r + 6'h01;
    expire_nxt = 1'b0;
    if (clear) begin
      state_nxt = WGST_T_IDLE;
      cnt_nxt = 17'h00000;
      pre_nxt = 6'h00;
    end else if (start) begin
      state_nxt = WGST_T_RUN;
      cnt_nxt = load_val;
      pre_nxt = 6'h00;
    end else begin
      unique case (state_r)
        WGST_T_IDLE: begin
          pre_nxt = 6'h00;
        end
        WGST_T_RUN: begin
          if (tick) begin
            pre_nxt = 6'h00;
            if (cnt_r == 17'h00001) begin
              expire_nxt = 1'b1;
              if (reload_en) begin
                cnt_nxt = load_val;
              end else begin
                state_nxt = WGST_T_IDLE;
                cnt_nxt = 17'h00000;
              end
            end else begin
              cnt_nxt = cnt_r - 17'h00001;
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      state_r <= WGST_T_IDLE;
      cnt_r <= 17'h00000;
      pre_r <= 6'h00;
      expire_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      pre_r <= pre_nxt;
      expire_r <= expire_nxt;
    end
  end

  assign running = (state_r == WGST_T_RUN);
  assign expire = expire_r;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  a_zero_full_count: assert property (@(posedge clk_sys) disable iff (srst)
    (start && !clear && init_count == 16'h0000) |=> (cnt_r == WGST_TCNT_FULL && running))
    else $error("zero initial count did not load full count");

  a_count_three_run: assert property (@(posedge clk_sys) disable iff (srst)
    (start && !clear && div_code == 3'h0 && init_count == 16'h0003 && !reload_en)
    ##1 (!start && !clear && !reload_en)[*3] |=> (!running && expire_r))
    else $error("count of three did not end after three cycles");

  a_expire_from_run: assert property (@(posedge clk_sys) disable iff (srst)
    expire_r |-> $past(running))
    else $error("expire without a running timer");

endmodule : wgst_wave_timer

// ### wgst_top.sv
// Module: waveform gate select, output polarity and waveform timers behind AHB-Lite
// Function
// - Each waveform channel can drive its own pulse generator start trigger.
// - Each pulse unit trigger ORs the triggers of channels selecting it.
// - A pulse unit trigger selected by no channel stays low.
// - Select 00, 01, 10 picks pulse unit 0, 2, 4 for trigger and input.
// - Reflection field 00 keeps the pulse input off the waveform outputs, except in mode 111 where it is the dead-time source.
// - Pass-through mode with reflection forwards the pulse input unchanged.
// - Reflection field is ignored in modes 100 and 111.
// - Polarity: 00 none, 01 both inverted, 10 output 0, 11 output 1.
// - Polarity applies in every operation mode.
// - Setup bits 15:14 are reserved; writes ignored.
// - Timer initial count register; zero means 65536.
// - Run time equals count times count clock period.
// - Modes 010, 100, 111: load on start, count down, stop at end.
// - Timer gives flag time in timer-pulse mode, dead time in dead modes.
// - Modes 000, 001: timer runs as free reload timer.
// - Count register writable any time; new value used at next start or reload.
// - Count and shutdown registers take halfword or word writes only.
// - Shutdown control register governs the emergency stop flag.
// - Mode codes 000, 001, 010, 100, 111; others prohibited.
// - Pulse unit select 11 is prohibited.
// - Writing a different mode resets the timer count state.
// - Count clock is system clock divided by 1 to 64 by code.
`timescale 1ns/100ps
module wgst_top
  import wgst_pkg::*;
(
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [1:0] hresp,
  output logic [31:0] hrdata,
  input wire logic [5:0] oc_rt_in,
  input wire logic pulse_unit0_output,
  input wire logic pulse_unit2_output,
  input wire logic pulse_unit4_output,
  input wire logic emergency_stop_input_n,
  output logic pulse_unit0_trigger,
  output logic pulse_unit2_trigger,
  output logic pulse_unit4_trigger,
  output logic [2:0] channel_start_trigger,
  output logic [5:0] waveform_output_pin,
  output logic [2:0] timer_reload_evt,
  output logic emergency_stop_flag
);

  // ****************************************************************
  // AHB-Lite slave
  // ****************************************************************
  logic acc;
  logic rd_pend_r, rd_pend_nxt;
  logic wr_pend_r, wr_pend_nxt;
  logic [7:0] ap_addr_r, ap_addr_nxt;
  logic [2:0] ap_size_r, ap_size_nxt;
  logic [1:0] ap_low_r, ap_low_nxt;
  logic [31:0] hrdata_r, hrdata_nxt;
  logic lane0, lane1, strict_ok;
  logic [15:0] rd16;

  logic [15:0] setup_r [3];
  logic [15:0] setup_nxt [3];
  logic [15:0] tcnt_r [3];
  logic [15:0] tcnt_nxt [3];
  logic [3:0] sd_r, sd_nxt;
  logic [2:0] runctl_r, runctl_nxt;
  logic [2:0] mode_clr_r, mode_clr_nxt;
  logic flag_r, flag_nxt;
  logic force_set, flag_clr;
  logic [2:0] t_run, t_exp;

  assign acc = hsel && htrans[1] && hready;
  assign hreadyout = !rd_pend_r;
  assign hresp = WGST_HRESP_OKAY;
  assign hrdata = hrdata_r;

  always_comb begin
    rd_pend_nxt = acc && !hwrite;
    wr_pend_nxt = acc && hwrite;
    ap_addr_nxt = acc ? haddr[7:0] : ap_addr_r;
    ap_size_nxt = acc ? hsize : ap_size_r;
    ap_low_nxt = acc ? haddr[1:0] : ap_low_r;
    ap_addr_nxt[1:0] = 2'h0;
    hrdata_nxt = hrdata_r;
    // Byte lanes of the low halfword
    lane0 = (ap_size_r == 3'h0) ? (ap_low_r == 2'h0) : !ap_low_r[1];
    lane1 = (ap_size_r == 3'h0) ? (ap_low_r == 2'h1) : !ap_low_r[1];
    strict_ok = (ap_size_r != 3'h0) && !ap_low_r[1];
    case (ap_addr_r)
      WGST_OFS_SETUP0: rd16 = setup_r[0] & WGST_SETUP_MASK;
      WGST_OFS_SETUP1: rd16 = setup_r[1] & WGST_SETUP_MASK;
      WGST_OFS_SETUP2: rd16 = setup_r[2] & WGST_SETUP_MASK;
      WGST_OFS_TCNT0: rd16 = tcnt_r[0];
      WGST_OFS_TCNT1: rd16 = tcnt_r[1];
      WGST_OFS_TCNT2: rd16 = tcnt_r[2];
      WGST_OFS_SHUTDOWN: rd16 = {12'h000, sd_r};
      WGST_OFS_RUNCTRL: rd16 = {13'h0000, runctl_r};
      WGST_OFS_STATUS: rd16 = {7'h00, flag_r, 5'h00, t_run};
      default: rd16 = 16'h0000;
    endcase
    if (rd_pend_r) begin
      hrdata_nxt = {16'h0000, rd16};
    end
  end

  // ****************************************************************
  // Register writes
  // ****************************************************************
  always_comb begin
    for (int c = 0; c < 3; c++) begin
      setup_nxt[c] = setup_r[c];
      tcnt_nxt[c] = tcnt_r[c];
    end
    sd_nxt = sd_r;
    runctl_nxt = runctl_r;
    mode_clr_nxt = 3'h0;
    force_set = 1'b0;
    flag_clr = 1'b0;
    if (wr_pend_r) begin
      for (int c = 0; c < 3; c++) begin
        if (ap_addr_r == WGST_OFS_SETUP0 + 8'(4 * c)) begin
          if (lane0) setup_nxt[c][7:0] = hwdata[7:0];
          if (lane1) setup_nxt[c][15:8] = {2'b00, hwdata[13:8]};
          mode_clr_nxt[c] = setup_nxt[c][WGST_MODE_LSB +: 3] !=
                            setup_r[c][WGST_MODE_LSB +: 3];
        end
        if (ap_addr_r == WGST_OFS_TCNT0 + 8'(4 * c) && strict_ok) begin
          tcnt_nxt[c] = hwdata[15:0];
        end
      end
      if (ap_addr_r == WGST_OFS_SHUTDOWN && strict_ok) begin
        sd_nxt = hwdata[3:0];
        force_set = hwdata[WGST_SD_FORCE_BIT];
      end
      if (ap_addr_r == WGST_OFS_RUNCTRL && lane0) begin
        runctl_nxt = hwdata[2:0];
      end
      if (ap_addr_r == WGST_OFS_STATUS && lane1) begin
        flag_clr = hwdata[WGST_STAT_FLAG_BIT];
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      rd_pend_r <= 1'b0;
      wr_pend_r <= 1'b0;
      ap_addr_r <= 8'h00;
      ap_size_r <= 3'h0;
      ap_low_r <= 2'h0;
      hrdata_r <= 32'h0000_0000;
      for (int c = 0; c < 3; c++) begin
        setup_r[c] <= WGST_SETUP_RST;
        tcnt_r[c] <= WGST_TCNT_RST;
      end
      sd_r <= WGST_SD_RST;
      runctl_r <= 3'h0;
      mode_clr_r <= 3'h0;
    end else begin
      rd_pend_r <= rd_pend_nxt;
      wr_pend_r <= wr_pend_nxt;
      ap_addr_r <= ap_addr_nxt;
      ap_size_r <= ap_size_nxt;
      ap_low_r <= ap_low_nxt;
      hrdata_r <= hrdata_nxt;
      for (int c = 0; c < 3; c++) begin
        setup_r[c] <= setup_nxt[c];
        tcnt_r[c] <= tcnt_nxt[c];
      end
      sd_r <= sd_nxt;
      runctl_r <= runctl_nxt;
      mode_clr_r <= mode_clr_nxt;
    end
  end

  // ****************************************************************
  // Waveform channels, gate routing and polarity
  // ****************************************************************
  logic [2:0] gate_r, gate_nxt;
  logic [2:0] prev_r, prev_nxt;
  logic [5:0] wave_r, wave_nxt;
  logic [2:0] t_start, t_reload, ch_pulse;
  logic [2:0] mode [3];
  logic [1:0] psel [3];

  always_comb begin
    for (int c = 0; c < 3; c++) begin
      mode[c] = setup_r[c][WGST_MODE_LSB +: 3];
      psel[c] = setup_r[c][WGST_PSEL_LSB +: 2];
    end
    // Pulse unit triggers and pulse inputs follow the selects directly
    pulse_unit0_trigger = 1'b0;
    pulse_unit2_trigger = 1'b0;
    pulse_unit4_trigger = 1'b0;
    for (int c = 0; c < 3; c++) begin
      pulse_unit0_trigger |= gate_r[c] && psel[c] == WGST_PSEL_U0;
      pulse_unit2_trigger |= gate_r[c] && psel[c] == WGST_PSEL_U2;
      pulse_unit4_trigger |= gate_r[c] && psel[c] == WGST_PSEL_U4;
      case (psel[c])
        WGST_PSEL_U0: ch_pulse[c] = pulse_unit0_output;
        WGST_PSEL_U2: ch_pulse[c] = pulse_unit2_output;
        WGST_PSEL_U4: ch_pulse[c] = pulse_unit4_output;
        default: ch_pulse[c] = 1'b0;
      endcase
    end
  end

  always_comb begin
    logic rt0, rt1, refl, gten, src, w0, w1;
    rt0 = 1'b0;
    rt1 = 1'b0;
    refl = 1'b0;
    gten = 1'b0;
    src = 1'b0;
    w0 = 1'b0;
    w1 = 1'b0;
    gate_nxt = 3'h0;
    prev_nxt = prev_r;
    wave_nxt = wave_r;
    t_start = 3'h0;
    t_reload = 3'h0;
    for (int c = 0; c < 3; c++) begin
      rt0 = oc_rt_in[2 * c];
      rt1 = oc_rt_in[2 * c + 1];
      gten = setup_r[c][WGST_GATE_LSB +: 2] != 2'h0;
      refl = setup_r[c][WGST_REFL_LSB +: 2] != 2'h0;
      src = (mode[c] == WGST_MODE_PDEAD) ? ch_pulse[c] : rt0;
      prev_nxt[c] = src;
      case (mode[c])
        WGST_MODE_THRU, WGST_MODE_RTPULSE: begin
          t_reload[c] = 1'b1;
          t_start[c] = runctl_r[c] && !t_run[c];
          if (mode[c] == WGST_MODE_THRU) begin
            w0 = refl ? ch_pulse[c] : rt0;
            w1 = refl ? ch_pulse[c] : rt1;
          end else begin
            w0 = refl ? (rt0 && ch_pulse[c]) : rt0;
            w1 = refl ? (rt1 && ch_pulse[c]) : rt1;
            gate_nxt[c] = gten && (rt0 || rt1);
          end
        end
        WGST_MODE_TPULSE: begin
          t_start[c] = src && !prev_r[c];
          w0 = refl ? (t_run[c] && ch_pulse[c]) : t_run[c];
          w1 = rt1;
          gate_nxt[c] = gten && t_run[c];
        end
        WGST_MODE_RTDEAD, WGST_MODE_PDEAD: begin
          // Reflection field has no say here; the dead time separates the pair
          t_start[c] = src != prev_r[c];
          w0 = src && !t_run[c] && !t_start[c];
          w1 = !src && !t_run[c] && !t_start[c];
          gate_nxt[c] = gten && mode[c] == WGST_MODE_PDEAD && rt0;
        end
        default: begin
          w0 = 1'b0;
          w1 = 1'b0;
        end
      endcase
      case (setup_r[c][WGST_POL_LSB +: 2])
        WGST_POL_NONE: wave_nxt[2 * c +: 2] = {w1, w0};
        WGST_POL_BOTH: wave_nxt[2 * c +: 2] = {!w1, !w0};
        WGST_POL_OUT0: wave_nxt[2 * c +: 2] = {w1, !w0};
        default: wave_nxt[2 * c +: 2] = {!w1, w0};
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      gate_r <= 3'h0;
      prev_r <= 3'h0;
      wave_r <= 6'h00;
    end else begin
      gate_r <= gate_nxt;
      prev_r <= prev_nxt;
      wave_r <= wave_nxt;
    end
  end

  assign channel_start_trigger = gate_r;
  assign waveform_output_pin = wave_r;
  assign timer_reload_evt = t_exp & t_reload;

  for (genvar g = 0; g < 3; g++) begin : g_tmr
    wgst_wave_timer u_tmr (
      .clk_sys(clk_sys),
      .srst(srst),
      .div_code(setup_r[g][WGST_DIV_LSB +: 3]),
      .init_count(tcnt_r[g]),
      .start(t_start[g]),
      .clear(mode_clr_r[g] || (t_reload[g] && !runctl_r[g])),
      .reload_en(t_reload[g]),
      .running(t_run[g]),
      .expire(t_exp[g])
    );
  end

  // ****************************************************************
  // Emergency stop input filter and flag
  // ****************************************************************
  logic [2:0] es_sync_r;
  logic [5:0] nz_cnt_r, nz_cnt_nxt;
  logic es_low, es_hit;

  always_comb begin
    es_low = !es_sync_r[1] && !es_sync_r[2];
    nz_cnt_nxt = es_low ? ((nz_cnt_r == 6'h3F) ? nz_cnt_r : nz_cnt_r + 6'h01) : 6'h00;
    es_hit = es_low && (7'(nz_cnt_r) + 7'h01 >= 7'(wgst_nz_width(sd_r[WGST_SD_NW_LSB +: 3])));
    flag_nxt = flag_r && !flag_clr;
    if ((sd_r[WGST_SD_EN_BIT] && es_hit) || force_set) begin
      flag_nxt = 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      es_sync_r <= 3'h7;
      nz_cnt_r <= 6'h00;
      flag_r <= 1'b0;
    end else begin
      es_sync_r <= {es_sync_r[1:0], emergency_stop_input_n};
      nz_cnt_r <= nz_cnt_nxt;
      flag_r <= flag_nxt;
    end
  end

  assign emergency_stop_flag = flag_r;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  a_gate_unit0_or: assert property (@(posedge clk_sys) disable iff (srst)
    (gate_r[1] && psel[1] == WGST_PSEL_U0) |-> pulse_unit0_trigger)
    else $error("selected channel trigger missing on unit 0");

  a_gate_unsel_low: assert property (@(posedge clk_sys) disable iff (srst)
    (psel[0] != WGST_PSEL_U2 && psel[1] != WGST_PSEL_U2 && psel[2] != WGST_PSEL_U2)
    |-> !pulse_unit2_trigger)
    else $error("unselected unit 2 trigger not low");

  a_thru_forward: assert property (@(posedge clk_sys) disable iff (srst)
    (mode[1] == WGST_MODE_THRU && setup_r[1][WGST_REFL_LSB +: 2] != 2'h0 &&
     setup_r[1][WGST_POL_LSB +: 2] == WGST_POL_NONE && psel[1] == WGST_PSEL_U2)
    |=> waveform_output_pin[2] == $past(pulse_unit2_output))
    else $error("pass-through pulse not forwarded");

  a_pol_invert_both: assert property (@(posedge clk_sys) disable iff (srst)
    (mode[0] == WGST_MODE_THRU && setup_r[0][WGST_REFL_LSB +: 2] == 2'h0 &&
     setup_r[0][WGST_POL_LSB +: 2] == WGST_POL_BOTH)
    |=> waveform_output_pin[1:0] == ~$past(oc_rt_in[1:0]))
    else $error("both outputs not inverted");

  a_reserved_read_zero: assert property (@(posedge clk_sys) disable iff (srst)
    (rd_pend_r && ap_addr_r == WGST_OFS_SETUP2) |=> (hrdata[15:14] == 2'b00 && hreadyout))
    else $error("reserved setup bits read nonzero");

  a_mode_change_stop: assert property (@(posedge clk_sys) disable iff (srst)
    mode_clr_nxt[0] |=> ##1 !t_run[0])
    else $error("mode change did not stop timer");

  a_byte_count_ignored: assert property (@(posedge clk_sys) disable iff (srst)
    (wr_pend_r && ap_addr_r == WGST_OFS_TCNT1 && ap_size_r == 3'h0) |=> $stable(tcnt_r[1]))
    else $error("byte write changed count register");

  a_flag_set_wins: assert property (@(posedge clk_sys) disable iff (srst)
    (sd_r[WGST_SD_EN_BIT] && es_hit && flag_clr) |=> emergency_stop_flag)
    else $error("flag clear beat a set");

  c_gate_to_unit4: cover property (@(posedge clk_sys) disable iff (srst) pulse_unit4_trigger);
  c_reload_event: cover property (@(posedge clk_sys) disable iff (srst) |timer_reload_evt);
  c_stop_flag: cover property (@(posedge clk_sys) disable iff (srst) $rose(emergency_stop_flag));
  c_dead_start: cover property (@(posedge clk_sys) disable iff (srst) t_start[0] && !t_reload[0]);

endmodule : wgst_top

// ### wgst_pulse_model.sv
// Behavioural pulse generator channels 0, 2 and 4 facing the gate selector
`timescale 1ns/100ps
module wgst_pulse_model #(
  parameter int LEN = 6
) (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic [2:0] trig,
  input wire logic [2:0] sw_start,
  output logic [2:0] pulse
);
  // ****************************************************************
  // Pulse per unit: gate rising edge or direct software start
  // ****************************************************************
  logic [2:0] trig_r;
  int cnt_r [3];
  always_ff @(posedge clk_sys) begin
    trig_r <= srst ? 3'h0 : trig;
    for (int i = 0; i < 3; i++) begin
      if (srst) begin
        cnt_r[i] <= 0;
      end else if ((trig[i] & ~trig_r[i]) | sw_start[i]) begin
        cnt_r[i] <= LEN;
      end else if (cnt_r[i] != 0) begin
        cnt_r[i] <= cnt_r[i] - 1;
      end
    end
  end
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      pulse[i] = (cnt_r[i] != 0);
    end
  end
endmodule : wgst_pulse_model

// ### waveform_gate_select_timer_test.sv
// Register-level testbench of the waveform gate select timer
`timescale 1ns/100ps
module waveform_gate_select_timer_test;
  import wgst_pkg::*;
  // ****************************************************************
  // Design, pulse unit model and bus helpers
  // ****************************************************************
  logic clk_sys = 1'b0, srst = 1'b1, hsel = 1'b1, hwrite = 1'b0, hreadyout, hready;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd, rd_s;
  logic [1:0] htrans = 2'h0, hresp;
  logic [2:0] hsize = 3'h2, pm, sw = 3'h0, cst, rld;
  logic [5:0] oc_rt_in = 6'h00, waveform_output_pin;
  logic pulse_unit0_output, pulse_unit2_output, pulse_unit4_output, esf, rdy_s;
  logic pulse_unit0_trigger, pulse_unit2_trigger, pulse_unit4_trigger;
  logic emergency_stop_input_n = 1'b1;
  int n_errors = 0, num_checks = 0, n;
  logic [1:0] pmask [4] = '{2'h0, 2'h3, 2'h1, 2'h2};
  assign hready = hreadyout;
  assign {pulse_unit4_output, pulse_unit2_output, pulse_unit0_output} = pm;
  always #2.5 clk_sys = ~clk_sys;
  always @(negedge clk_sys) begin
    rdy_s <= hreadyout;
    rd_s <= hrdata;
  end
  wgst_top dut_u (.clk_sys, .srst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready, .hreadyout, .hresp, .hrdata, .oc_rt_in, .pulse_unit0_output,
    .pulse_unit2_output, .pulse_unit4_output, .emergency_stop_input_n, .pulse_unit0_trigger,
    .pulse_unit2_trigger, .pulse_unit4_trigger, .channel_start_trigger(cst),
    .waveform_output_pin, .timer_reload_evt(rld), .emergency_stop_flag(esf));
  wgst_pulse_model pm_u (.clk_sys, .srst, .sw_start(sw), .pulse(pm),
    .trig({pulse_unit4_trigger, pulse_unit2_trigger, pulse_unit0_trigger}));
  task wait_rdy;
    do @(posedge clk_sys); while (rdy_s !== 1'b1);
  endtask : wait_rdy
  task ahb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge clk_sys);
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    wait_rdy;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy;
    r = rd_s;
  endtask : ahb
  task chk(input string s, input logic [31:0] e, input logic [31:0] v);
    num_checks++;
    if (v !== e) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", s, e, v);
    end
  endtask : chk
  task rt(input logic [5:0] v);
    @(posedge clk_sys) oc_rt_in <= v;
    repeat (2) @(negedge clk_sys);
  endtask : rt
  task hi_cnt(input int b, output int c);
    c = 0;
    repeat (60) begin
      @(negedge clk_sys);
      c += (waveform_output_pin[b] === 1'b1);
    end
  endtask : hi_cnt
  function logic [31:0] su(logic [2:0] m, logic [1:0] p, logic [1:0] r, logic [1:0] o);
    return {18'h0, o, r, p, 2'h1, m, 3'h0};
  endfunction : su
  task report_and_stop;
    if (n_errors == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : report_and_stop
  initial begin
    repeat (20000) @(posedge clk_sys);
    n_errors++;
    report_and_stop;
  end
  // ****************************************************************
  // Test sequence
  // ****************************************************************
  initial begin
    repeat (6) @(posedge clk_sys);
    srst <= 1'b0;
    ahb(0, WGST_OFS_SETUP0, 0, rd);
    chk("setup0 reset", 32'h0, rd);
    ahb(0, WGST_OFS_TCNT1, 0, rd);
    chk("count1 reset", 32'h0, rd);
    chk("idle triggers", 3'h0, {pulse_unit4_trigger, pulse_unit2_trigger, pulse_unit0_trigger});
    ahb(1, WGST_OFS_SETUP2, 32'h0000FFFF, rd);
    ahb(0, WGST_OFS_SETUP2, 0, rd);
    chk("reserved bits", 32'h00003FFF, rd);
    ahb(0, 8'h40, 0, rd);
    chk("unmapped read", 32'h0, rd);
    for (int c = 0; c < 3; c++) ahb(1, 8'(4 * c), su(3'h1, 2'(c), 0, 0), rd);
    for (int c = 0; c < 3; c++) begin
      rt(6'h01 << (2 * c));
      chk("own unit", 3'h1 << c, {pulse_unit4_trigger, pulse_unit2_trigger, pulse_unit0_trigger});
      chk("channel trigger", 3'h1 << c, cst);
    end
    for (int c = 0; c < 3; c++) ahb(1, 8'(4 * c), su(3'h1, 0, 0, 0), rd);
    rt(6'h08);
    chk("shared unit", 3'h1, {pulse_unit4_trigger, pulse_unit2_trigger, pulse_unit0_trigger});
    for (int m = 0; m < 2; m++) begin
      for (int o = 0; o < 4; o++) begin
        ahb(1, WGST_OFS_SETUP0, su(3'(m), 0, 0, 2'(o)), rd);
        rt(6'h01);
        chk("polarity", 2'h1 ^ pmask[o], waveform_output_pin[1:0]);
      end
    end
    rt(6'h00);
    for (int r = 0; r < 2; r++) begin
      ahb(1, WGST_OFS_SETUP1, su(3'h0, 2'h1, 2'(1 - r), 0), rd);
      @(posedge clk_sys) sw <= 3'h2;
      @(posedge clk_sys) sw <= 3'h0;
      hi_cnt(2, n);
      chk("reflected pulse", (r == 0) ? 6 : 0, n);
    end
    ahb(1, WGST_OFS_TCNT0, 32'h3, rd);
    ahb(1, WGST_OFS_SETUP0, su(3'h2, 0, 0, 0), rd);
    rt(6'h01);
    hi_cnt(0, n);
    chk("timer span", 3, n);
    rt(6'h00);
    ahb(1, WGST_OFS_SETUP0, su(3'h2, 0, 0, 0) | 32'h1, rd);
    ahb(1, WGST_OFS_TCNT0, 32'h2, rd);
    rt(6'h01);
    hi_cnt(0, n);
    chk("divided span", 4, n);
    chk("okay response", WGST_HRESP_OKAY, hresp);
    hsize <= 3'h0;
    ahb(1, WGST_OFS_TCNT1, 32'h1234, rd);
    hsize <= 3'h2;
    ahb(0, WGST_OFS_TCNT1, 0, rd);
    chk("byte write", 32'h0, rd);
    ahb(1, WGST_OFS_TCNT2, 32'h2, rd);
    ahb(1, WGST_OFS_RUNCTRL, 32'h4, rd);
    repeat (4) @(posedge clk_sys);
    n = 0;
    repeat (20) begin
      @(negedge clk_sys);
      n += (rld[2] === 1'b1);
    end
    chk("reload events", 10, n);
    ahb(1, WGST_OFS_RUNCTRL, 32'h0, rd);
    ahb(1, WGST_OFS_SHUTDOWN, 32'h1, rd);
    @(posedge clk_sys) emergency_stop_input_n <= 1'b0;
    repeat (6) @(negedge clk_sys);
    chk("stop flag", 1, esf);
    ahb(1, WGST_OFS_STATUS, 32'h100, rd);
    @(negedge clk_sys);
    chk("set beats clear", 1, esf);
    @(posedge clk_sys) emergency_stop_input_n <= 1'b1;
    repeat (4) @(posedge clk_sys);
    ahb(1, WGST_OFS_STATUS, 32'h100, rd);
    @(negedge clk_sys);
    chk("flag cleared", 0, esf);
    ahb(1, WGST_OFS_SHUTDOWN, 32'h10, rd);
    @(negedge clk_sys);
    chk("forced flag", 1, esf);
    @(posedge clk_sys) srst <= 1'b1;
    repeat (6) @(posedge clk_sys);
    srst <= 1'b0;
    ahb(0, WGST_OFS_SETUP1, 0, rd);
    chk("setup1 after reset", 32'h0, rd);
    chk("flag after reset", 0, esf);
    report_and_stop;
  end
endmodule : waveform_gate_select_timer_test
